// ==== mpc_cfg.svh ====
`ifndef MPC_CFG_SVH
`define MPC_CFG_SVH
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define MPC_OFS_PROFILE      8'h98
`define MPC_OFS_TUNING       8'h9A
`define MPC_RST_PROFILE      32'h00000000
`define MPC_RST_TUNING       32'h00000000
// ----------------------------------------
// Field positions (low bit)
// ----------------------------------------
`define MPC_PARITY_BIT       31
`define MPC_STEP0_LSB        28
`define MPC_STEP_W           3
`define MPC_ADV_LSB          5
`define MPC_NEG_LSB          16
`define MPC_HYST_BIT         15
`define MPC_BEMF_LSB         10
`define MPC_CYC_LSB          7
`define MPC_XANG_LSB         2
`define MPC_DIV_LSB          0
`endif

// ==== mpc_config_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mpc_cfg.svh"

// What this block does
// [RULE1] Eight 3-bit step duties, step zero on top
// [RULE2] Duty codes decode 0 to 99 percent
// [RULE3] Step four decodes with same levels
// [RULE4] Two-bit lead angle: 0,5,10,15 degrees
// [RULE5] Surge negative limit code maps to counts
// [RULE6] Hysteresis bit selects 20 or 10
// [RULE7] Profile register at 98h, resets zero
// [RULE8] Tuning register at 9Ah, resets zero
// [RULE9] Back-EMF threshold is 200 times code
// [RULE10] Cycle threshold 2 to 23 step 3
// [RULE11] Open-loop crossing angle 5,8,12,15 degrees
// [RULE12] Startup rate factor 1,2,4,8
// [RULE13] Reserved bits stored, no effect, reset zero
// [RULE14] Parity bit stored, never changed internally
module mpc_config_bank (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Register port
  input  wire logic [7:0]         addr_i,
  input  wire logic               wr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               rd_i,
  output logic      [31:0]        rdata_o,
  // Decoded configuration
  output mpc_pkg::mpc_decoded_t   cfg_o
);

  mpc_pkg::mpc_state_t s_r;
  mpc_pkg::mpc_state_t s_nxt;

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic logic [13:0] duty_of(input logic [2:0] c);
    case (c)
      3'h0:    duty_of = 14'h0000;
      3'h1:    duty_of = 14'h1388;
      3'h2:    duty_of = 14'h1D4C;
      3'h3:    duty_of = 14'h20B7;
      3'h4:    duty_of = 14'h222E;
      3'h5:    duty_of = 14'h249F;
      3'h6:    duty_of = 14'h2616;
      default: duty_of = 14'h26AC;
    endcase
  endfunction : duty_of

  function automatic logic signed [7:0] neg_of(input logic [2:0] c);
    case (c)
      3'h0:    neg_of = 8'sh00;
      3'h1:    neg_of = -8'sh28;
      3'h2:    neg_of = -8'sh1E;
      3'h3:    neg_of = -8'sh14;
      3'h4:    neg_of = -8'sh0A;
      3'h5:    neg_of = 8'sh0A;
      3'h6:    neg_of = 8'sh14;
      default: neg_of = 8'sh1E;
    endcase
  endfunction : neg_of

  function automatic logic [4:0] xang_of(input logic [1:0] c);
    case (c)
      2'h0:    xang_of = 5'h05;
      2'h1:    xang_of = 5'h08;
      2'h2:    xang_of = 5'h0C;
      default: xang_of = 5'h0F;
    endcase
  endfunction : xang_of

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Whole words stored, so reserved and parity bits hold what was written
    if (wr_i && addr_i == `MPC_OFS_PROFILE) begin // [RULE7] [RULE13] [RULE14]
      s_nxt.profile = wdata_i;
    end
    if (wr_i && addr_i == `MPC_OFS_TUNING) begin // [RULE8] [RULE13] [RULE14]
      s_nxt.tuning = wdata_i;
    end
    // Read data is registered; unmapped offsets return zero
    if (rd_i) begin
      case (addr_i)
        `MPC_OFS_PROFILE: s_nxt.rdata = s_r.profile;
        `MPC_OFS_TUNING:  s_nxt.rdata = s_r.tuning;
        default:          s_nxt.rdata = 32'h00000000;
      endcase
    end
    if (rst_i) begin
      s_nxt.profile = `MPC_RST_PROFILE; // [RULE7]
      s_nxt.tuning  = `MPC_RST_TUNING; // [RULE8]
      s_nxt.rdata   = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign rdata_o = s_r.rdata;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_step
      // Step g sits g fields below the top; step four uses the same table
      assign cfg_o.step_duty[g] = duty_of(
        s_r.profile[`MPC_STEP0_LSB - `MPC_STEP_W*g +: `MPC_STEP_W]); // [RULE1] [RULE2] [RULE3]
    end
  endgenerate

  logic [1:0] adv_c;
  logic [2:0] neg_c;
  logic [4:0] bemf_c;
  logic [2:0] cyc_c;
  logic [1:0] xang_c;
  logic [1:0] div_c;
  assign adv_c  = s_r.profile[`MPC_ADV_LSB +: 2];
  assign neg_c  = s_r.tuning[`MPC_NEG_LSB +: 3];
  assign bemf_c = s_r.tuning[`MPC_BEMF_LSB +: 5];
  assign cyc_c  = s_r.tuning[`MPC_CYC_LSB +: 3];
  assign xang_c = s_r.tuning[`MPC_XANG_LSB +: 2];
  assign div_c  = s_r.tuning[`MPC_DIV_LSB +: 2];

  assign cfg_o.angle_adv_deg = 5'(adv_c) * 5'h05; // [RULE4]
  assign cfg_o.neg_limit     = neg_of(neg_c); // [RULE5]
  // Positive limit = hysteresis (20 or 10) plus negative limit value
  assign cfg_o.pos_limit     = neg_of(neg_c)
                               + (s_r.tuning[`MPC_HYST_BIT] ? 8'sh0A : 8'sh14); // [RULE6]
  assign cfg_o.bemf_thr      = 13'(bemf_c) * 13'h0C8; // [RULE9]
  assign cfg_o.cycle_thr     = 5'h02 + 5'(cyc_c) * 5'h03; // [RULE10]
  assign cfg_o.xing_angle_deg = xang_of(xang_c); // [RULE11]
  assign cfg_o.rate_factor   = 4'h1 << div_c; // [RULE12]

  // ----------------------------------------
  // Register checks
  // ----------------------------------------
  a_profile_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    wr_i && addr_i == `MPC_OFS_PROFILE |=> s_r.profile == $past(wdata_i))
    else $error("profile write not stored");
  a_tuning_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    wr_i && addr_i == `MPC_OFS_TUNING |=> s_r.tuning == $past(wdata_i))
    else $error("tuning write not stored");
  // Reset is checked with no disable, since the reset itself is the trigger
  a_reset_zero: assert property (@(posedge clk_i) // [RULE7]
    rst_i |=> s_r.profile == 32'h00000000 && s_r.tuning == 32'h00000000)
    else $error("registers not zero after reset");
  a_hold_value: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    !wr_i |=> $stable(s_r.profile) && $stable(s_r.tuning))
    else $error("register changed without write");
  a_other_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    wr_i && addr_i != `MPC_OFS_PROFILE && addr_i != `MPC_OFS_TUNING
    |=> $stable(s_r.profile) && $stable(s_r.tuning))
    else $error("unmapped write changed a register");
  a_read_back: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    rd_i && !wr_i && addr_i == `MPC_OFS_TUNING |=> rdata_o == s_r.tuning)
    else $error("tuning read data mismatch");
  a_read_profile: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    rd_i && !wr_i && addr_i == `MPC_OFS_PROFILE |=> rdata_o == s_r.profile)
    else $error("profile read data mismatch");
  // Read data must not drift between reads; software may sample it late
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    !rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  // Only mapped fields may move the decode; reserved and parity bits stay inert
  a_reserved_free: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    $stable(s_r.profile[30:5]) && $stable(s_r.tuning[18:7]) && $stable(s_r.tuning[3:0])
    |-> $stable(cfg_o))
    else $error("reserved bits changed decode");

  // ----------------------------------------
  // Decode checks
  // ----------------------------------------
  // Spot checks against fixed table entries, independent of the decode code
  a_step_zero: assert property (@(posedge clk_i) // [RULE1]
    s_r.profile[30:28] == 3'h7 |-> cfg_o.step_duty[0] == 14'h26AC)
    else $error("step zero decode wrong");
  a_step_three: assert property (@(posedge clk_i) // [RULE2]
    s_r.profile[21:19] == 3'h5 |-> cfg_o.step_duty[3] == 14'h249F)
    else $error("step three decode wrong");
  a_step_four: assert property (@(posedge clk_i) // [RULE3]
    s_r.profile[18:16] == 3'h3 |-> cfg_o.step_duty[4] == 14'h20B7)
    else $error("step four decode wrong");
  a_step_seven: assert property (@(posedge clk_i) // [RULE2]
    s_r.profile[9:7] == 3'h1 |-> cfg_o.step_duty[7] == 14'h1388)
    else $error("step seven decode wrong");
  a_advance_top: assert property (@(posedge clk_i) // [RULE4]
    s_r.profile[6:5] == 2'h3 |-> cfg_o.angle_adv_deg == 5'h0F)
    else $error("angle advance wrong");
  a_neg_low: assert property (@(posedge clk_i) // [RULE5]
    s_r.tuning[18:16] == 3'h1 |-> cfg_o.neg_limit == -8'sh28)
    else $error("negative limit low code wrong");
  a_neg_high: assert property (@(posedge clk_i) // [RULE5]
    s_r.tuning[18:16] == 3'h7 |-> cfg_o.neg_limit == 8'sh1E)
    else $error("negative limit top code wrong");
  a_hyst_sum: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    cfg_o.pos_limit - cfg_o.neg_limit == (s_r.tuning[15] ? 8'sh0A : 8'sh14))
    else $error("positive limit wrong");
  a_bemf_top: assert property (@(posedge clk_i) // [RULE9]
    s_r.tuning[14:10] == 5'h1F |-> cfg_o.bemf_thr == 13'h1838)
    else $error("back-emf threshold wrong");
  a_cycle_thr: assert property (@(posedge clk_i) // [RULE10]
    s_r.tuning[9:7] == 3'h7 |-> cfg_o.cycle_thr == 5'h17)
    else $error("cycle threshold wrong");
  a_cycle_low: assert property (@(posedge clk_i) // [RULE10]
    s_r.tuning[9:7] == 3'h0 |-> cfg_o.cycle_thr == 5'h02)
    else $error("cycle threshold low code wrong");
  a_xing_angle: assert property (@(posedge clk_i) // [RULE11]
    s_r.tuning[3:2] == 2'h2 |-> cfg_o.xing_angle_deg == 5'h0C)
    else $error("crossing angle wrong");
  a_rate_top: assert property (@(posedge clk_i) // [RULE12]
    s_r.tuning[1:0] == 2'h3 |-> cfg_o.rate_factor == 4'h8)
    else $error("rate factor wrong");

endmodule : mpc_config_bank
`default_nettype wire

// ==== mpc_config_bank_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mpc_cfg.svh"
module mpc_config_bank_tb;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic                  clk_i   = 1'b0;
  logic                  rst_i   = 1'b1;
  logic [7:0]            addr_i  = 8'h00;
  logic                  wr_i    = 1'b0;
  logic                  rd_i    = 1'b0;
  logic [31:0]           wdata_i = 32'h00000000;
  logic [31:0]           rdata_o;
  mpc_pkg::mpc_decoded_t cfg_o;
  logic [31:0]           rd;
  logic [31:0]           p;
  logic [31:0]           t;
  logic [2:0]            c;
  int                    n_errors    = 0;
  int                    check_count = 0;
  int                    cycles      = 0;
  int                    duty[8] = '{0, 5000, 7500, 8375, 8750, 9375, 9750, 9900};
  int                    negl[8] = '{0, -40, -30, -20, -10, 10, 20, 30};
  int                    xang[4] = '{5, 8, 12, 15};

  mpc_config_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_o(cfg_o));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Sequence needs under a hundred cycles; the ceiling of 5000 leaves wide margin
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic test_done;
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Decode checks for the codes that the loop puts in for index i
  task automatic chk_cfg(input int i);
    for (int g = 0; g < 8; g++)
      chk("step", 32'(cfg_o.step_duty[g]), 32'(duty[(i + g) % 8]));
    chk("advance", 32'(cfg_o.angle_adv_deg), 32'(5 * (i % 4)));
    chk("neg limit", 32'(cfg_o.neg_limit), 32'(negl[i]));
    chk("pos limit", 32'(cfg_o.pos_limit), 32'(negl[i] + (i % 2 ? 10 : 20)));
    chk("bemf", 32'(cfg_o.bemf_thr), 32'(200 * ((i % 4) * 8 + i)));
    chk("cycles", 32'(cfg_o.cycle_thr), 32'(2 + 3 * i));
    chk("xing angle", 32'(cfg_o.xing_angle_deg), 32'(xang[i % 4]));
    chk("rate", 32'(cfg_o.rate_factor), 32'(1 << (i % 4)));
  endtask : chk_cfg

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    addr_i  = a;
    wdata_i = d;
    wr_i    = 1'b1;
    @(negedge clk_i);
    wr_i    = 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_i);
    addr_i = a;
    rd_i   = 1'b1;
    @(negedge clk_i);
    rd_i   = 1'b0;
    d      = rdata_o;
  endtask : rdr

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    rdr(`MPC_OFS_PROFILE, rd);
    chk("profile reset", rd, `MPC_RST_PROFILE);
    rdr(`MPC_OFS_TUNING, rd);
    chk("tuning reset", rd, `MPC_RST_TUNING);
    // Each step gets a different code so a swapped field shows up
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      p = 32'h00000000;
      for (int g = 0; g < 8; g++) p[30-3*g -: 3] = 3'(i + g);
      p[6:5] = c[1:0];
      t = {13'h0000, c, c[0], c[1:0], c, c, 3'h0, c[1:0], c[1:0]};
      wr(`MPC_OFS_PROFILE, p);
      wr(`MPC_OFS_TUNING, t);
      chk_cfg(i);
      rdr(`MPC_OFS_PROFILE, rd);
      chk("profile rb", rd, p);
      rdr(`MPC_OFS_TUNING, rd);
      chk("tuning rb", rd, t);
    end
    // Same mapped fields with reserved and parity bits set: decode must not move
    p = p | 32'h8000001F;
    t = t | 32'hFFF80070;
    wr(`MPC_OFS_PROFILE, p);
    wr(`MPC_OFS_TUNING, t);
    chk_cfg(7);
    rdr(`MPC_OFS_PROFILE, rd);
    chk("profile spare", rd, p);
    rdr(`MPC_OFS_TUNING, rd);
    chk("tuning spare", rd, t);
    wr(8'h99, 32'hFFFFFFFF);
    rdr(8'h99, rd);
    chk("unmapped", rd, 32'h00000000);
    rdr(`MPC_OFS_PROFILE, rd);
    chk("profile kept", rd, p);
    rdr(`MPC_OFS_TUNING, rd);
    chk("tuning kept", rd, t);
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    rdr(`MPC_OFS_TUNING, rd);
    chk("tuning rerst", rd, `MPC_RST_TUNING);
    rdr(`MPC_OFS_PROFILE, rd);
    chk("profile rerst", rd, `MPC_RST_PROFILE);
    chk("rate rerst", 32'(cfg_o.rate_factor), 32'h00000001);
    chk("pos rerst", 32'(cfg_o.pos_limit), 32'h00000014);
    chk("cycles rerst", 32'(cfg_o.cycle_thr), 32'h00000002);
    chk("angle rerst", 32'(cfg_o.xing_angle_deg), 32'h00000005);
    chk("duty rerst", 32'(cfg_o.step_duty[0]), 32'h00000000);
    test_done();
  end
endmodule : mpc_config_bank_tb
`default_nettype wire

// ==== mpc_pkg.sv ====
`default_nettype none
package mpc_pkg;
  // Duty in units of 0.01 percent, angles in degrees, limits in raw counts
  typedef struct packed {
    logic        [7:0][13:0] step_duty;
    logic        [4:0]       angle_adv_deg;
    logic signed [7:0]       neg_limit;
    logic signed [7:0]       pos_limit;
    logic        [12:0]      bemf_thr;
    logic        [4:0]       cycle_thr;
    logic        [4:0]       xing_angle_deg;
    logic        [3:0]       rate_factor;
  } mpc_decoded_t;

  typedef struct packed {
    logic [31:0] profile;
    logic [31:0] tuning;
    logic [31:0] rdata;
  } mpc_state_t;
endpackage : mpc_pkg
`default_nettype wire
